// ---- logic/rtc_cfg.svh ----
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH
// location map
`define LOC_MAIN_STATUS 5'h00
`define LOC_PERIODIC_FLAG 5'h03
`define LOC_OUTPUT_MODE 5'h02
`define LOC_IRQ_CTRL0 5'h03
`define LOC_IRQ_CTRL1 5'h04
`define LOC_CNT_FIRST 5'h05
`define LOC_CNT_LAST 5'h0c
// main status bits
`define MS_IRQ_BIT 0
`define MS_POWER_FAIL_IN_N_BIT 1
`define MS_PERIODIC_BIT 3
`define MS_BLOCK_BIT 6
// timing
`define CLK_PERIOD_NS 10
`define LOCKOUT_MIN_US 30
`define LOCKOUT_MAX_US 63
`define IRQ_DELAY_NS 16500
`define TICK_HZ 100
`define CLK_HZ 100000000
// synchroniser reset: osc, standby low, power good, strobes idle high
`define SYNC_IDLE 11'h1ff
`endif

// ---- logic/rtc_pkg.sv ----
`default_nettype none
package rtc_pkg;
  typedef enum logic [1:0] {ACC_IDLE, ACC_READ, ACC_WRITE} acc_state_t;
endpackage
`default_nettype wire

// ---- logic/bcd_digit_counter.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "rtc_cfg.svh"
module bcd_digit_counter
(
  // clock
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic enable_i,
  // counting
  input wire logic inc_i,
  input wire logic [7:0] min_i,
  input wire logic [7:0] max_i,
  input wire logic load_i,
  input wire logic [7:0] load_value_i,
  output logic [7:0] value_o,
  output logic carry_o
);
  logic [7:0] value_q;
  logic [7:0] value_d;
  logic at_max;
  logic [7:0] bcd_inc;
  assign at_max = (value_q == max_i);
  assign bcd_inc = (value_q[3:0] == 4'h9) ?
    {value_q[7:4] + 4'h1, 4'h0} : {value_q[7:4], value_q[3:0] + 4'h1};
  assign carry_o = inc_i && at_max;
  assign value_d = load_i ? load_value_i :
    (!inc_i ? value_q : (at_max ? min_i : bcd_inc));
  assign value_o = value_q;
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
      value_q <= 8'h00;
    else if (enable_i)
      value_q <= value_d;
  end
endmodule
`default_nettype wire

// ---- logic/rtc_host_port.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "rtc_cfg.svh"
module rtc_host_port
#(
  parameter int TICK_DIV = `CLK_HZ / `TICK_HZ,
  parameter int LOCKOUT_CYC = (`LOCKOUT_MIN_US * 1000 + `CLK_PERIOD_NS - 1)
                              / `CLK_PERIOD_NS,
  parameter int IRQ_DELAY_CYC = `IRQ_DELAY_NS / `CLK_PERIOD_NS
)
(
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic enable_i,
  // host bus
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [4:0] location_select_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  // power and outputs
  input wire logic power_fail_in_n_i,
  input wire logic battery_mode_i,
  input wire logic osc_i,
  output logic irq_out_n_o,
  output logic irq_oe_o,
  output logic multi_function_out_o,
  output logic multi_function_oe_o,
  output logic lockout_o
);
  // ****************************************
  // synchronisers
  // ****************************************
  logic [10:0] meta_q;
  logic [10:0] sync_q;
  logic [7:0] dsync_meta_q;
  logic [7:0] dsync_q;
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      // idle pin levels, so no false standby level follows reset
      meta_q <= `SYNC_IDLE;
      sync_q <= `SYNC_IDLE;
      dsync_meta_q <= 8'h00;
      dsync_q <= 8'h00;
    end
    else if (enable_i)
    begin
      meta_q <= {osc_i, battery_mode_i, power_fail_in_n_i,
                 location_select_i, cs_n_i, rd_n_i, wr_n_i};
      sync_q <= meta_q;
      dsync_meta_q <= data_i;
      dsync_q <= dsync_meta_q;
    end
  end
  logic s_osc, s_batt, s_pf_n, s_cs_n, s_rd_n, s_wr_n;
  logic [4:0] s_loc;
  assign s_osc = sync_q[10];
  assign s_batt = sync_q[9];
  assign s_pf_n = sync_q[8];
  assign s_loc = sync_q[7:3];
  assign s_cs_n = sync_q[2];
  assign s_rd_n = sync_q[1];
  assign s_wr_n = sync_q[0];

  // ****************************************
  // power fail lockout
  // ****************************************
  logic [$clog2(LOCKOUT_CYC+1)-1:0] pf_cnt_q;
  logic lockout_q;
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      pf_cnt_q <= '0;
      lockout_q <= 1'b0;
    end
    else if (enable_i)
    begin
      if (s_pf_n)
      begin
        pf_cnt_q <= '0;
        lockout_q <= 1'b0;
      end
      else if (pf_cnt_q == LOCKOUT_CYC[$bits(pf_cnt_q)-1:0])
        lockout_q <= 1'b1;
      else
        pf_cnt_q <= pf_cnt_q + 1'b1;
    end
  end

  // ****************************************
  // access state machine
  // ****************************************
  rtc_pkg::acc_state_t state_q, state_d;
  logic [4:0] loc_q;
  logic rd_act, wr_act, wr_end;
  assign rd_act = !s_cs_n && !s_rd_n;
  assign wr_act = !s_cs_n && !s_wr_n;
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      rtc_pkg::ACC_IDLE:
        if (!lockout_q && rd_act)
          state_d = rtc_pkg::ACC_READ;
        else if (!lockout_q && wr_act)
          state_d = rtc_pkg::ACC_WRITE;
      rtc_pkg::ACC_READ:
        if (!rd_act)
          state_d = rtc_pkg::ACC_IDLE;
      rtc_pkg::ACC_WRITE:
        if (!wr_act)
          state_d = rtc_pkg::ACC_IDLE;
      default:
        state_d = rtc_pkg::ACC_IDLE;
    endcase
  end
  // write lands when strobe pair ends, even if lockout sets after it began
  assign wr_end = (state_q == rtc_pkg::ACC_WRITE) && !wr_act;
  logic rd_end;
  assign rd_end = (state_q == rtc_pkg::ACC_READ) && !rd_act;
  logic [7:0] wdata_q;
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      state_q <= rtc_pkg::ACC_IDLE;
      loc_q <= 5'h00;
      wdata_q <= 8'h00;
    end
    else if (enable_i)
    begin
      state_q <= state_d;
      if (state_q == rtc_pkg::ACC_IDLE && !lockout_q)
        loc_q <= s_loc;
      if (state_q == rtc_pkg::ACC_WRITE && wr_act)
        wdata_q <= dsync_q;
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  logic block_sel_q;
  logic [7:0] out_mode_q, irq_ctrl0_q, irq_ctrl1_q, periodic_q;
  logic run_q, hour12_q;
  logic periodic_flag_q, power_fail_in_n_flag_q;
  logic tick;
  logic [7:0] cnt_val [8];
  logic [7:0] carry;
  function automatic logic is_cnt(input logic [4:0] loc);
    is_cnt = (loc >= `LOC_CNT_FIRST) && (loc <= `LOC_CNT_LAST);
  endfunction
  logic wr_ms, wr_om, wr_ic0, wr_ic1, rd_pf;
  assign wr_ms = wr_end && (loc_q == `LOC_MAIN_STATUS);
  assign wr_om = wr_end && block_sel_q && (loc_q == `LOC_OUTPUT_MODE);
  assign wr_ic0 = wr_end && block_sel_q && (loc_q == `LOC_IRQ_CTRL0);
  assign wr_ic1 = wr_end && block_sel_q && (loc_q == `LOC_IRQ_CTRL1);
  assign rd_pf = rd_end && !block_sel_q && (loc_q == `LOC_PERIODIC_FLAG);
  // periodic flags: bit 0 set on each tick, bit n set on carry out of byte n-1
  logic [7:0] periodic_set;
  assign periodic_set = tick ? {carry[6:0], 1'b1} & {8{run_q}} : 8'h00;
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      block_sel_q <= 1'b0;
      out_mode_q <= 8'h00;
      irq_ctrl0_q <= 8'h00;
      irq_ctrl1_q <= 8'h00;
      periodic_q <= 8'h00;
      periodic_flag_q <= 1'b0;
      power_fail_in_n_flag_q <= 1'b0;
    end
    else if (enable_i)
    begin
      if (wr_ms)
        block_sel_q <= wdata_q[`MS_BLOCK_BIT];
      if (wr_om)
        out_mode_q <= wdata_q;
      if (wr_ic0)
        irq_ctrl0_q <= wdata_q;
      if (wr_ic1)
        irq_ctrl1_q <= wdata_q;
      // set beats the read-clear
      periodic_q <= (rd_pf ? 8'h00 : periodic_q) | periodic_set;
      if ((|(periodic_set & irq_ctrl0_q)))
        periodic_flag_q <= 1'b1;
      else if (wr_ms && wdata_q[`MS_PERIODIC_BIT])
        periodic_flag_q <= 1'b0;
      // stays set until power returns
      power_fail_in_n_flag_q <= irq_ctrl1_q[7] && !s_pf_n;
    end
  end
  assign run_q = out_mode_q[7];
  assign hour12_q = out_mode_q[6];

  // ****************************************
  // prescaler and counter chain
  // ****************************************
  logic [$clog2(TICK_DIV)-1:0] pre_q;
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i || !run_q)
      pre_q <= '0;
    else if (enable_i)
      pre_q <= (pre_q == TICK_DIV[$bits(pre_q)-1:0] - 1'b1) ? '0 :
               pre_q + 1'b1;
  end
  assign tick = run_q && (pre_q == TICK_DIV[$bits(pre_q)-1:0] - 1'b1);
  // order: hundredths, sec, min, hour, dom, month, year, dow
  logic [7:0] cmin [8];
  logic [7:0] cmax [8];
  logic [7:0] hours_bcd;
  logic meridian_q;
  assign hours_bcd = cnt_val[3];
  always_comb
  begin
    cmin = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h01};
    cmax = '{8'h99, 8'h59, 8'h59, 8'h23, 8'h31, 8'h12, 8'h99, 8'h07};
    cmin[3] = hour12_q ? 8'h01 : 8'h00;
    cmax[3] = hour12_q ? 8'h12 : 8'h23;
  end
  logic [7:0] incs;
  logic hour_to_12;
  logic day_carry;
  // 12 h clock changes day on 11 pm to 12 am, not on the 12 to 1 wrap
  assign day_carry = hour12_q ? (hour_to_12 && meridian_q) : carry[3];
  assign incs = {day_carry, carry[5:4], day_carry, carry[2:0], tick};
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_cnt
      logic ld;
      // counters answer in both blocks
      assign ld = wr_end && (loc_q == `LOC_CNT_FIRST + 5'(gi));
      bcd_digit_counter u_cnt
      (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .enable_i(enable_i),
        .inc_i(incs[gi]),
        .min_i(cmin[gi]),
        .max_i(cmax[gi]),
        .load_i(ld),
        .load_value_i(gi == 3 ? {1'b0, wdata_q[6:0]} : wdata_q),
        .value_o(cnt_val[gi]),
        .carry_o(carry[gi])
      );
    end
  endgenerate
  // hour carry: 11 -> 12 toggles meridian in 12 h mode
  assign hour_to_12 = carry[2] && hour12_q && (hours_bcd == 8'h11);
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
      meridian_q <= 1'b0;
    else if (enable_i)
    begin
      if (g_cnt[3].ld)
        meridian_q <= wdata_q[7];
      else if (hour_to_12)
        meridian_q <= ~meridian_q;
    end
  end

  // ****************************************
  // read mux and data pins
  // ****************************************
  logic [7:0] main_status, rd_mux;
  logic irq_pend;
  assign irq_pend = periodic_flag_q || power_fail_in_n_flag_q;
  assign main_status = {1'b0, block_sel_q, 2'b00, periodic_flag_q, 1'b0,
                        power_fail_in_n_flag_q, irq_pend};
  assign rd_mux = (loc_q == `LOC_MAIN_STATUS) ? main_status :
    is_cnt(loc_q) ? ((loc_q == `LOC_CNT_FIRST + 5'h3) ?
      {meridian_q & hour12_q, hours_bcd[6:0]} :
      cnt_val[3'(loc_q - `LOC_CNT_FIRST)]) :
    (block_sel_q && loc_q == `LOC_OUTPUT_MODE) ? out_mode_q :
    (block_sel_q && loc_q == `LOC_IRQ_CTRL0) ? irq_ctrl0_q :
    (block_sel_q && loc_q == `LOC_IRQ_CTRL1) ? irq_ctrl1_q :
    (!block_sel_q && loc_q == `LOC_PERIODIC_FLAG) ? periodic_q : 8'h00;
  // irq delay after a periodic or power fail flag sets, approximates pin latency
  logic [$clog2(IRQ_DELAY_CYC+1)-1:0] irq_cnt_q;
  logic irq_q, oe_q, mfo_q, mfo_oe_q;
  logic [7:0] dout_q;
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      irq_cnt_q <= '0;
      irq_q <= 1'b0;
      oe_q <= 1'b0;
      dout_q <= 8'h00;
      mfo_q <= 1'b0;
      mfo_oe_q <= 1'b0;
    end
    else if (enable_i)
    begin
      if (!irq_pend)
      begin
        irq_cnt_q <= '0;
        irq_q <= 1'b0;
      end
      else if (irq_cnt_q == IRQ_DELAY_CYC[$bits(irq_cnt_q)-1:0])
        irq_q <= 1'b1;
      else
        irq_cnt_q <= irq_cnt_q + 1'b1;
      oe_q <= (state_d == rtc_pkg::ACC_READ) && (s_pf_n || !lockout_q)
              && !(!s_pf_n && state_q != rtc_pkg::ACC_READ);
      dout_q <= rd_mux;
      mfo_q <= out_mode_q[0] ? s_osc : power_fail_in_n_flag_q;
      mfo_oe_q <= !s_batt || (out_mode_q[0] ? s_osc : power_fail_in_n_flag_q);
    end
  end
  assign data_o = dout_q;
  assign data_oe_o = oe_q;
  assign irq_out_n_o = 1'b0;
  assign irq_oe_o = irq_q;
  assign multi_function_out_o = mfo_q;
  assign multi_function_oe_o = mfo_oe_q;
  assign lockout_o = lockout_q;
endmodule
`default_nettype wire

// ---- testbench/rtc_port_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module rtc_port_checker
#(
  parameter int LOCKOUT_CYC = 5
)
(
  // clock and host strobes
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  // power
  input wire logic power_fail_in_n_i,
  input wire logic battery_mode_i,
  // outputs
  input wire logic data_oe_o,
  input wire logic irq_out_n_o,
  input wire logic irq_oe_o,
  input wire logic multi_function_out_o,
  input wire logic multi_function_oe_o,
  input wire logic lockout_o
);
  // sync delay plus the lockout count, with slack
  localparam int LK_MAX = LOCKOUT_CYC + 6;
  wire rd_act = !cs_n_i && !rd_n_i;
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (!reset_n_i);
  // ****************
  // properties
  // ****************
  property p_oe_cause;
    data_oe_o |-> rd_act || $past(rd_act) || $past(rd_act, 2)
      || $past(rd_act, 3);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("oe w/o read");
  property p_oe_idle;
    rd_n_i [*5] |-> !data_oe_o;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("oe stuck");
  property p_oe_answer;
    (rd_act && power_fail_in_n_i && !lockout_o) [*6] |-> data_oe_o;
  endproperty
  a_oe_answer: assert property (p_oe_answer) else $error("no oe");
  property p_lock_new;
    lockout_o |-> !$rose(data_oe_o);
  endproperty
  a_lock_new: assert property (p_lock_new) else $error("locked read");
  property p_lock_min;
    $fell(power_fail_in_n_i) |-> !lockout_o [*5];
  endproperty
  a_lock_min: assert property (p_lock_min) else $error("early lock");
  property p_lock_max;
    $fell(power_fail_in_n_i) |-> ##[1:LK_MAX] lockout_o;
  endproperty
  a_lock_max: assert property (p_lock_max) else $error("late lock");
  property p_irq_pin;
    irq_oe_o |-> !irq_out_n_o;
  endproperty
  a_irq_pin: assert property (p_irq_pin) else $error("irq not low");
  property p_irq_level;
    $rose(irq_oe_o) |-> irq_oe_o [*4];
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq pulse");
  property p_mfo_od;
    // two sync stages plus the output flop before standby takes hold
    battery_mode_i [*4] |-> !(multi_function_oe_o && !multi_function_out_o);
  endproperty
  a_mfo_od: assert property (p_mfo_od) else $error("mfo drives low");
  c_read: cover property (rd_act ##3 data_oe_o);
  c_lock: cover property ($rose(lockout_o));
  c_irq: cover property ($rose(irq_oe_o));
endmodule
bind rtc_host_port rtc_port_checker #(.LOCKOUT_CYC(LOCKOUT_CYC)) u_chk (
  .clock_i, .reset_n_i, .cs_n_i, .rd_n_i, .power_fail_in_n_i,
  .battery_mode_i, .data_oe_o, .irq_out_n_o, .irq_oe_o,
  .multi_function_out_o, .multi_function_oe_o, .lockout_o);
`default_nettype wire

// ---- testbench/host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_model
(
  // clock
  input wire logic clock_i,
  // bus
  input wire logic data_oe_i,
  input wire logic [7:0] rd_data_i,
  output logic cs_n_o = 1'b1,
  output logic rd_n_o = 1'b1,
  output logic wr_n_o = 1'b1,
  output logic [4:0] addr_o = 5'h1f,
  output logic [7:0] data_o = 8'h00
);
  // released lines show the inverse, not the last value
  task automatic idle();
    repeat (4) @(negedge clock_i);
    addr_o = ~addr_o;
    data_o = ~data_o;
    repeat (3) @(negedge clock_i);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge clock_i);
    addr_o = a;
    data_o = d;
    @(negedge clock_i);
    cs_n_o = 1'b0;
    wr_n_o = 1'b0;
    repeat (8) @(negedge clock_i);
    wr_n_o = 1'b1;
    cs_n_o = 1'b1;
    idle();
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d,
    output logic s);
    @(negedge clock_i);
    addr_o = a;
    @(negedge clock_i);
    cs_n_o = 1'b0;
    rd_n_o = 1'b0;
    repeat (7) @(negedge clock_i);
    // sampled at the falling edge, away from the launching edge
    s = data_oe_i;
    d = rd_data_i;
    @(negedge clock_i);
    rd_n_o = 1'b1;
    cs_n_o = 1'b1;
    idle();
  endtask
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock_i, reset_n_i, power_fail_in_n_i, battery_mode_i;
  logic osc_i = 1'b0;
  logic cs_n, rd_n, wr_n, data_oe, irq_n, irq_oe, multi_function_out, mfo_oe, lockout;
  logic [4:0] loc;
  logic [7:0] wdata, rdata;
  int bad_count = 0;
  int checked = 0;
  int cyc = 0;
  logic [7:0] start_v [8] = '{8'h99, 8'h59, 8'h59, 8'h00, 8'h31, 8'h12,
    8'h99, 8'h07};
  logic [7:0] wrap_v [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01,
    8'h00, 8'h01};
  // ****************
  // design and host
  // ****************
  rtc_host_port #(.TICK_DIV(200), .LOCKOUT_CYC(5), .IRQ_DELAY_CYC(3)) u_dut (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .enable_i(1'b1),
    .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n), .location_select_i(loc),
    .data_i(wdata), .data_o(rdata), .data_oe_o(data_oe),
    .power_fail_in_n_i(power_fail_in_n_i), .battery_mode_i(battery_mode_i),
    .osc_i(osc_i), .irq_out_n_o(irq_n), .irq_oe_o(irq_oe),
    .multi_function_out_o(multi_function_out), .multi_function_oe_o(mfo_oe),
    .lockout_o(lockout));
  host_model u_host (.clock_i(clock_i), .data_oe_i(data_oe),
    .rd_data_i(rdata), .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n),
    .addr_o(loc), .data_o(wdata));
  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  always #7 osc_i = ~osc_i;
  // ****************
  // checking
  // ****************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (bad_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic get(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic s;
    u_host.rd(a, d, s);
    check(d, e);
  endtask
  // cy: carry reaches the day counters
  task automatic t_roll(input logic [7:0] hr, input logic [7:0] mode,
    input logic [7:0] hr_x, input logic cy);
    logic [7:0] d;
    logic s;
    int n;
    u_host.wr(5'h00, 8'h40);
    u_host.wr(5'h02, mode);
    u_host.wr(5'h03, 8'h01);
    for (int i = 0; i < 8; i++)
      u_host.wr(5'(5 + i), (i == 3) ? hr : start_v[i]);
    for (int i = 0; i < 8; i++)
      get(5'(5 + i), (i == 3) ? hr : start_v[i]);
    u_host.wr(5'h02, mode | 8'h80);
    n = 0;
    do
    begin
      u_host.rd(5'h05, d, s);
      n++;
    end
    while (d === 8'h99 && n < 40);
    u_host.wr(5'h02, mode);
    check({7'h00, n < 40}, 8'h01);
    for (int i = 0; i < 8; i++)
      get(5'(5 + i), (i == 3) ? hr_x : (i < 3 || cy) ? wrap_v[i] :
        start_v[i]);
  endtask
  task automatic t_irq();
    check({7'h00, irq_oe}, 8'h01);
    u_host.wr(5'h00, 8'h00);
    get(5'h03, 8'hff);
    get(5'h03, 8'h00);
    u_host.wr(5'h00, 8'h08);
    check({7'h00, irq_oe}, 8'h00);
  endtask
  task automatic t_lock();
    logic [7:0] d;
    logic s;
    u_host.wr(5'h04, 8'h80);
    fork
      u_host.rd(5'h06, d, s);
      begin
        repeat (6) @(negedge clock_i);
        battery_mode_i = 1'b1;
        power_fail_in_n_i = 1'b0;
      end
    join
    check({s, d[6:0]}, 8'h80);
    repeat (10) @(negedge clock_i);
    check({7'h00, lockout}, 8'h01);
    check({6'h00, multi_function_out, mfo_oe}, 8'h03);
    u_host.wr(5'h06, 8'h42);
    u_host.rd(5'h06, d, s);
    check({7'h00, s}, 8'h00);
    power_fail_in_n_i = 1'b1;
    battery_mode_i = 1'b0;
    repeat (20) @(negedge clock_i);
    get(5'h06, 8'h00);
    check({6'h00, multi_function_out, mfo_oe}, 8'h01);
  endtask
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      bad_count++;
      close_out();
    end
  end
  initial
  begin
    reset_n_i = 1'b0;
    power_fail_in_n_i = 1'b1;
    battery_mode_i = 1'b0;
    repeat (5) @(negedge clock_i);
    reset_n_i = 1'b1;
    repeat (3) @(negedge clock_i);
    t_roll(8'h23, 8'h00, 8'h00, 1'b1);
    t_irq();
    t_roll(8'h11, 8'h40, 8'h92, 1'b0);
    t_roll(8'h92, 8'h40, 8'h81, 1'b0);
    t_lock();
    close_out();
  end
endmodule
`default_nettype wire
